/* src/processor_init_sequencer.sv */
// Processor init sequencer: hard and soft initialization, optional self-test,
// start state of the architectural registers and the fetch enable.
// Assumes a power-on clear pin and soft-init pulses from the interrupt unit.
`timescale 1ns/1ps
module processor_init_sequencer
#(
   parameter int          N_ARRAYS     = 4,
   parameter int          SELF_TEST_CYC = pis_pkg::SELF_TEST_CYC_DEF,
   // Arbitrary value, stands for the family/model/stepping code
   parameter logic [63:0] DATA_ID      = pis_pkg::DATA_ID_DEF
)
(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                power_on_clear_n,
   input  wire logic                soft_init_ipi,
   input  wire logic                self_test_enable,
   input  wire logic [N_ARRAYS-1:0] array_fault,
   output pis_pkg::pis_state_t      state,
   output logic                     fetch_enable,
   output logic                     real_mode,
   output logic                     init_busy,
   output logic                     self_test_busy,
   output logic [63:0]              ctrl0,
   output logic [63:0]              flags,
   output logic [63:0]              instr_ptr,
   output logic [15:0]              code_sel,
   output logic [63:0]              code_base,
   output logic [31:0]              seg_limit,
   output logic [63:0]              accumulator_register,
   output logic [63:0]              data_register,
   output logic [15:0]              fp_ctrl,
   output logic [15:0]              fp_tag,
   output logic [31:0]              media_csr,
   output logic                     tsc_clear
);
   import pis_pkg::*;

   localparam int HW = $clog2(SOFT_HOLD_CYC + 1);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic poc_meta, poc_sync, ste_meta, ste_sync;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Clear counts as asserted in reset, so no fetch slips out before the pin is seen
         poc_meta <= 1'b1;
         poc_sync <= 1'b1;
         ste_meta <= 1'b0;
         ste_sync <= 1'b0;
      end
      else
      begin
         poc_meta <= ~power_on_clear_n;
         poc_sync <= poc_meta;
         ste_meta <= self_test_enable;
         ste_sync <= ste_meta;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   pis_state_t    next_state;
   logic [HW-1:0] hold;
   logic [HW-1:0] next_hold;
   logic          st_start;
   logic          st_done;
   logic          st_failed;
   logic          hard_load;
   logic          soft_load;

   pis_self_test
   #(
      .N_ARRAYS (N_ARRAYS),
      .TEST_CYC (SELF_TEST_CYC)
   )
   u_self_test
   (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .start       (st_start),
      .array_fault (array_fault),
      .busy        (self_test_busy),
      .done        (st_done),
      .failed      (st_failed)
   );

   always_comb
   begin
      next_state = state;
      next_hold  = hold;
      st_start   = 1'b0;
      hard_load  = 1'b0;
      soft_load  = 1'b0;
      if (poc_sync)
      begin
         next_state = PIS_HARD_HOLD;
         hard_load  = 1'b1;
      end
      else
      begin
         unique case (state)
            PIS_HARD_HOLD:
            begin
               if (ste_sync)
               begin
                  next_state = PIS_SELF_TEST;
                  st_start   = 1'b1;
               end
               else
               begin
                  next_state = PIS_RUN;
               end
            end
            PIS_SELF_TEST:
            begin
               if (st_done)
               begin
                  next_state = PIS_RUN;
               end
            end
            PIS_SOFT_HOLD:
            begin
               if (hold == '0)
               begin
                  next_state = PIS_RUN;
               end
               else
               begin
                  next_hold = hold - HW'(1);
               end
            end
            PIS_RUN:
            begin
               next_state = PIS_RUN;
            end
         endcase
         // Soft init from any state but PIS_SELF_TEST after power-up; restarts a hold in progress
         if (soft_init_ipi && state != PIS_SELF_TEST)
         begin
            next_state = PIS_SOFT_HOLD;
            next_hold  = HW'(SOFT_HOLD_CYC - 1);
            soft_load  = 1'b1;
            st_start   = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= PIS_HARD_HOLD;
         hold  <= '0;
      end
      else
      begin
         state <= next_state;
         hold  <= next_hold;
      end
   end

   always_comb
   begin
      fetch_enable = (state == PIS_RUN) && !poc_sync;
      init_busy    = (state != PIS_RUN);
   end

   // ------------------------------------------------------------
   // Architectural start state
   // ------------------------------------------------------------
   logic [63:0] next_ctrl0, next_flags, next_ip, next_base, next_acc, next_data;
   logic [15:0] next_sel, next_fpc, next_fpt;
   logic [31:0] next_limit, next_mcsr;
   logic        next_real, next_tsc;

   always_comb
   begin
      next_ctrl0 = ctrl0;
      next_flags = flags;
      next_ip    = instr_ptr;
      next_sel   = code_sel;
      next_base  = code_base;
      next_limit = seg_limit;
      next_acc   = accumulator_register;
      next_data  = data_register;
      next_fpc   = fp_ctrl;
      next_fpt   = fp_tag;
      next_mcsr  = media_csr;
      next_real  = real_mode;
      next_tsc   = 1'b0;
      if (hard_load || soft_load)
      begin
         // Shared values on both routes
         next_real  = 1'b1;
         next_flags = FLAGS_RESET;
         next_ip    = IP_RESET;
         next_sel   = CODE_SEL_RESET;
         next_base  = CODE_BASE_RESET;
         next_limit = SEG_LIMIT_RESET;
         next_acc   = ACC_CLEAR;
         next_data  = DATA_ID;
      end
      if (hard_load)
      begin
         next_ctrl0 = CTRL0_HARD_RESET;
         next_fpc   = FP_CTRL_RESET;
         next_fpt   = FP_TAG_RESET;
         next_mcsr  = MEDIA_CSR_RESET;
         next_tsc   = 1'b1;
      end
      else if (soft_load)
      begin
         // Cache disable bits and the floating/media state survive soft init
         next_ctrl0 = CTRL0_HARD_RESET & ~(64'h1 << CTRL0_CD_BIT) & ~(64'h1 << CTRL0_NW_BIT)
                    | (ctrl0 & ((64'h1 << CTRL0_CD_BIT) | (64'h1 << CTRL0_NW_BIT)));
      end
      if (st_done && state == PIS_SELF_TEST && !hard_load)
      begin
         next_acc = st_failed ? ACC_FAIL : ACC_CLEAR;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl0                <= CTRL0_HARD_RESET;
         flags                <= FLAGS_RESET;
         instr_ptr            <= IP_RESET;
         code_sel             <= CODE_SEL_RESET;
         code_base            <= CODE_BASE_RESET;
         seg_limit            <= SEG_LIMIT_RESET;
         accumulator_register <= ACC_CLEAR;
         data_register        <= DATA_ID;
         fp_ctrl              <= FP_CTRL_RESET;
         fp_tag               <= FP_TAG_RESET;
         media_csr            <= MEDIA_CSR_RESET;
         real_mode            <= 1'b1;
         tsc_clear            <= 1'b1;
      end
      else
      begin
         ctrl0                <= next_ctrl0;
         flags                <= next_flags;
         instr_ptr            <= next_ip;
         code_sel             <= next_sel;
         code_base            <= next_base;
         seg_limit            <= next_limit;
         accumulator_register <= next_acc;
         data_register        <= next_data;
         fp_ctrl              <= next_fpc;
         fp_tag               <= next_fpt;
         media_csr            <= next_mcsr;
         real_mode            <= next_real;
         tsc_clear            <= next_tsc;
      end
   end
endmodule

/* src/pis_pkg.sv */
// Package for the processor init sequencer: states, start values, timings.
// Assumes a single core clock domain at 10 MHz.
package pis_pkg;

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PIS_HARD_HOLD,
      PIS_SELF_TEST,
      PIS_SOFT_HOLD,
      PIS_RUN
   } pis_state_t;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 100;
   localparam int SOFT_HOLD_NS       = 400;
   localparam int SOFT_HOLD_CYC      = (SOFT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELF_TEST_CYC_DEF  = 3000000;

   // ------------------------------------------------------------
   // Start values of the architectural state
   // ------------------------------------------------------------
   localparam logic [63:0] CTRL0_HARD_RESET   = 64'h0000_0000_6000_0010;
   localparam int          CTRL0_CD_BIT       = 30;
   localparam int          CTRL0_NW_BIT       = 29;
   localparam logic [63:0] FLAGS_RESET        = 64'h0000_0000_0000_0002;
   localparam logic [63:0] IP_RESET           = 64'h0000_0000_0000_fff0;
   localparam logic [15:0] CODE_SEL_RESET     = 16'hf000;
   localparam logic [63:0] CODE_BASE_RESET    = 64'h0000_0000_ffff_0000;
   localparam logic [31:0] SEG_LIMIT_RESET    = 32'h0000_ffff;
   localparam logic [15:0] FP_CTRL_RESET      = 16'h0040;
   localparam logic [15:0] FP_TAG_RESET       = 16'h5555;
   localparam logic [31:0] MEDIA_CSR_RESET    = 32'h0000_1f80;
   localparam logic [63:0] ACC_CLEAR          = 64'h0000_0000_0000_0000;
   localparam logic [63:0] ACC_FAIL           = 64'h0000_0000_0000_0001;
   localparam logic [63:0] DATA_ID_DEF        = 64'h0000_0000_0000_0a5a;

endpackage

/* src/pis_self_test.sv */
// Self-test engine: counts a test run and gathers array fault flags.
// Assumes fault flags come from logic on the same clock.
`timescale 1ns/1ps
module pis_self_test
#(
   parameter int N_ARRAYS = 4,
   parameter int TEST_CYC = 3000000
)
(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                start,
   input  wire logic [N_ARRAYS-1:0] array_fault,
   output logic                     busy,
   output logic                     done,
   output logic                     failed
);
   import pis_pkg::*;

   localparam int CW = $clog2(TEST_CYC + 1);

   logic [CW-1:0]       count;
   logic [CW-1:0]       next_count;
   logic [N_ARRAYS-1:0] seen;
   logic [N_ARRAYS-1:0] next_seen;
   logic                next_busy;
   logic                next_done;
   logic                next_failed;

   // ------------------------------------------------------------
   // Per-array sticky fault capture
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N_ARRAYS; g++)
      begin : g_arr
         always_comb
         begin
            next_seen[g] = start ? 1'b0 : (seen[g] | (busy & array_fault[g]));
         end
      end
   endgenerate

   always_comb
   begin
      next_count  = count;
      next_busy   = busy;
      next_done   = 1'b0;
      next_failed = failed;
      if (start)
      begin
         next_count  = CW'(TEST_CYC - 1);
         next_busy   = 1'b1;
         next_failed = 1'b0;
      end
      else if (busy)
      begin
         if (count == '0)
         begin
            next_busy   = 1'b0;
            next_done   = 1'b1;
            next_failed = |next_seen;
         end
         else
         begin
            next_count = count - CW'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count  <= '0;
         seen   <= '0;
         busy   <= 1'b0;
         done   <= 1'b0;
         failed <= 1'b0;
      end
      else
      begin
         count  <= next_count;
         seen   <= next_seen;
         busy   <= next_busy;
         done   <= next_done;
         failed <= next_failed;
      end
   end
endmodule

/* bench/pis_monitor.sv */
// Checker for the init sequencer, bound to its top module.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
module pis_monitor
   import pis_pkg::*;
#(
   parameter int N_ARRAYS      = 4,
   parameter int SELF_TEST_CYC = 20
)
(
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic                power_on_clear_n,
   input wire logic                soft_init_ipi,
   input wire logic [N_ARRAYS-1:0] array_fault,
   input wire pis_state_t          state,
   input wire logic                fetch_enable,
   input wire logic                real_mode,
   input wire logic [63:0]         ctrl0,
   input wire logic [63:0]         instr_ptr,
   input wire logic [15:0]         code_sel,
   input wire logic [63:0]         accumulator_register,
   input wire logic [15:0]         fp_ctrl,
   input wire logic [31:0]         media_csr,
   input wire logic                tsc_clear
);
   localparam int T_LIM = SELF_TEST_CYC + 4;
   logic fault_seen;
   logic next_fault_seen;

   // ----------------------------------------
   // Faults gathered over one test run
   // ----------------------------------------
   always_comb
   begin
      next_fault_seen = (state == PIS_SELF_TEST) && (fault_seen || (|array_fault));
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         fault_seen <= 1'b0;
      else
         fault_seen <= next_fault_seen;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_fetch_run;
      fetch_enable |-> state == PIS_RUN;
   endproperty
   property p_hold;
      (!power_on_clear_n) [*4] |-> !fetch_enable && state == PIS_HARD_HOLD;
   endproperty
   property p_hard_vals;
      state == PIS_HARD_HOLD |-> ctrl0 == CTRL0_HARD_RESET && instr_ptr == IP_RESET
         && code_sel == CODE_SEL_RESET && media_csr == MEDIA_CSR_RESET;
   endproperty
   property p_exit;
      $rose(power_on_clear_n) ##1 power_on_clear_n [*2] |=> state != PIS_HARD_HOLD;
   endproperty
   // Pin must have been high long enough that no hard hold is pending
   sequence s_soft_req;
      power_on_clear_n [*3] ##0 (soft_init_ipi && state == PIS_RUN);
   endsequence
   property p_soft_take;
      s_soft_req |=> state == PIS_SOFT_HOLD && accumulator_register == ACC_CLEAR
         && ctrl0[28:0] == CTRL0_HARD_RESET[28:0] && $stable(fp_ctrl)
         && $stable(media_csr) && !tsc_clear;
   endproperty
   property p_soft_len;
      $rose(state == PIS_SOFT_HOLD) |-> (state == PIS_SOFT_HOLD) [*4];
   endproperty
   property p_soft_exit;
      $rose(state == PIS_SOFT_HOLD) ##0 (!soft_init_ipi) [*4] |=> state == PIS_RUN;
   endproperty
   property p_test_len;
      $rose(state == PIS_SELF_TEST) |-> ##[8:T_LIM] state == PIS_RUN;
   endproperty
   property p_test_result;
      state == PIS_SELF_TEST ##1 state == PIS_RUN
         |-> accumulator_register == (fault_seen ? ACC_FAIL : ACC_CLEAR);
   endproperty
   property p_refuse;
      state == PIS_SELF_TEST && soft_init_ipi |=> state != PIS_SOFT_HOLD;
   endproperty
   property p_real;
      state == PIS_RUN |-> real_mode;
   endproperty

   a_fetch_run: assert property (p_fetch_run) else $error("fetch outside run");
   a_hold: assert property (p_hold) else $error("no hold under clear pin");
   a_hard_vals: assert property (p_hard_vals) else $error("bad hard values");
   a_exit: assert property (p_exit) else $error("hard hold not left");
   a_soft_take: assert property (p_soft_take) else $error("bad soft init");
   a_soft_len: assert property (p_soft_len) else $error("soft hold too short");
   a_soft_exit: assert property (p_soft_exit) else $error("soft hold not left");
   a_test_len: assert property (p_test_len) else $error("self-test length");
   a_test_result: assert property (p_test_result) else $error("bad test result");
   a_refuse: assert property (p_refuse) else $error("soft init in test");
   a_real: assert property (p_real) else $error("not real mode");

   c_soft: cover property ($rose(state == PIS_SOFT_HOLD));
   c_fail: cover property (state == PIS_SELF_TEST ##1 accumulator_register != ACC_CLEAR);
   c_hard: cover property ($fell(power_on_clear_n));
endmodule

bind processor_init_sequencer pis_monitor
#(
   .N_ARRAYS      (N_ARRAYS),
   .SELF_TEST_CYC (SELF_TEST_CYC)
)
u_mon
(
   .mclk                 (mclk),
   .rst_n                (rst_n),
   .power_on_clear_n     (power_on_clear_n),
   .soft_init_ipi        (soft_init_ipi),
   .array_fault          (array_fault),
   .state                (state),
   .fetch_enable         (fetch_enable),
   .real_mode            (real_mode),
   .ctrl0                (ctrl0),
   .instr_ptr            (instr_ptr),
   .code_sel             (code_sel),
   .accumulator_register (accumulator_register),
   .fp_ctrl              (fp_ctrl),
   .media_csr            (media_csr),
   .tsc_clear            (tsc_clear)
);

/* bench/pis_sys_model.sv */
// System side: power-on clear pin and soft-init interrupt source.
// Assumes the bench calls its tasks; drives on falling edges.
`timescale 1ns/1ps
module pis_sys_model
(
   input  wire logic mclk,
   output logic      power_on_clear_n,
   output logic      soft_init_ipi
);
   // Power comes up with the pin asserted
   initial
   begin
      power_on_clear_n = 1'b0;
      soft_init_ipi    = 1'b0;
   end

   task automatic set_pin(input logic v);
      @(negedge mclk);
      power_on_clear_n = v;
   endtask

   task automatic send_ipi();
      @(negedge mclk);
      soft_init_ipi = 1'b1;
      @(negedge mclk);
      soft_init_ipi = 1'b0;
   endtask
endmodule

/* bench/tb_processor_init_sequencer.sv */
// Bench: random soft inits, hard inits with self-test, mid-run reset.
// Assumes the checker is bound in and the system model drives the pins.
`timescale 1ns/1ps
module tb_processor_init_sequencer;
   import pis_pkg::*;
   localparam int N_AR = 4;
   logic            mclk;
   logic            rst_n;
   logic            ste;
   logic [N_AR-1:0] fault;
   wire logic       pin;
   wire logic       interprocessor_interrupt;
   pis_state_t      state;
   logic            fetch_enable, real_mode, init_busy, st_busy, tsc_clear;
   logic [63:0]     ctrl0, flags, instr_ptr, code_base, acc, data_reg;
   logic [15:0]     code_sel, fp_ctrl, fp_tag;
   logic [31:0]     seg_limit, media_csr;
   int              miscompares, n_checks;

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   pis_sys_model sys (.mclk(mclk), .power_on_clear_n(pin), .soft_init_ipi(interprocessor_interrupt));

   processor_init_sequencer #(.N_ARRAYS(N_AR), .SELF_TEST_CYC(20)) dut
   (
      .mclk(mclk), .rst_n(rst_n), .power_on_clear_n(pin), .soft_init_ipi(interprocessor_interrupt),
      .self_test_enable(ste), .array_fault(fault), .state(state),
      .fetch_enable(fetch_enable), .real_mode(real_mode), .init_busy(init_busy),
      .self_test_busy(st_busy), .ctrl0(ctrl0), .flags(flags), .instr_ptr(instr_ptr),
      .code_sel(code_sel), .code_base(code_base), .seg_limit(seg_limit),
      .accumulator_register(acc), .data_register(data_reg), .fp_ctrl(fp_ctrl),
      .fp_tag(fp_tag), .media_csr(media_csr), .tsc_clear(tsc_clear)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [63:0] exp_acc(input logic [N_AR-1:0] f);
      return (f != '0) ? ACC_FAIL : ACC_CLEAR;
   endfunction

   // Bounded wait; the caller's compare catches a hang
   task automatic wait_st(input pis_state_t s);
      int n;
      n = 0;
      while (state !== s && n < 60)
      begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic chk_start();
      chk(ctrl0, CTRL0_HARD_RESET);
      chk(flags, FLAGS_RESET);
      chk(instr_ptr, IP_RESET);
      chk(code_sel, CODE_SEL_RESET);
      chk(code_base, CODE_BASE_RESET);
      chk(seg_limit, SEG_LIMIT_RESET);
      chk(real_mode, 1'b1);
      chk(fp_ctrl, FP_CTRL_RESET);
      chk(fp_tag, FP_TAG_RESET);
      chk(media_csr, MEDIA_CSR_RESET);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #(3000 * 100);
      miscompares++;
      end_sim();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      logic [N_AR-1:0] f;
      rst_n = 1'b0;
      ste = 1'b0;
      fault = '0;
      void'($urandom(14));
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      chk(fetch_enable, 1'b0);
      chk(state, PIS_HARD_HOLD);
      repeat (3) @(negedge mclk);
      chk(state, PIS_HARD_HOLD);
      chk(fetch_enable, 1'b0);
      chk(tsc_clear, 1'b1);
      chk(data_reg, DATA_ID_DEF);
      sys.set_pin(1'b1);
      wait_st(PIS_RUN);
      chk(state, PIS_RUN);
      chk(fetch_enable, 1'b1);
      chk_start();
      for (int i = 0; i < 8; i++)
      begin
         fault = N_AR'($urandom_range(0, 15));
         repeat ($urandom_range(0, 4)) @(negedge mclk);
         sys.send_ipi();
         if (i % 2 == 1)
            sys.send_ipi();
         chk(state, PIS_SOFT_HOLD);
         chk(acc, ACC_CLEAR);
         chk(tsc_clear, 1'b0);
         chk(init_busy, 1'b1);
         repeat (SOFT_HOLD_CYC - 1) @(negedge mclk);
         chk(fetch_enable, 1'b0);
         @(negedge mclk);
         chk(state, PIS_RUN);
         chk_start();
      end
      for (int k = 0; k < 4; k++)
      begin
         f = (k == 0) ? '0 : (k == 1) ? 4'h8 : N_AR'($urandom_range(0, 15));
         fault = f;
         ste = 1'b1;
         sys.set_pin(1'b0);
         repeat (4) @(negedge mclk);
         sys.send_ipi();
         chk(state, PIS_HARD_HOLD);
         sys.set_pin(1'b1);
         wait_st(PIS_SELF_TEST);
         chk(st_busy, 1'b1);
         sys.send_ipi();
         chk(state, PIS_SELF_TEST);
         wait_st(PIS_RUN);
         chk(state, PIS_RUN);
         chk(acc, exp_acc(f));
      end
      ste = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      chk(state, PIS_HARD_HOLD);
      chk(acc, ACC_CLEAR);
      rst_n = 1'b1;
      wait_st(PIS_RUN);
      chk(fetch_enable, 1'b1);
      end_sim();
   end
endmodule
